// >>> dv/sfb_host_model.sv
// Host controller model that drives the serial flash bus pins.
`timescale 1ns/1ps
`default_nettype none
module sfb_host_model (
	input  wire logic       clk,
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe_n,
	output var  logic [3:0] line,
	output var  logic       sclk,
	output var  logic       sel_n,
	output var  logic       rst_n
);
	logic [3:0] hv;
	logic [3:0] hen;
	logic       tgl;
	logic       mode3;

	// Select and reset start inactive and are driven from time zero.
	initial
	begin
		sel_n = 1'b1;
		rst_n = 1'b1;
		sclk  = 1'b0;
		mode3 = 1'b0;
		hv    = 4'h0;
		hen   = 4'h0;
		tgl   = 1'b0;
	end

	// A released line shows a level that changes every cycle, never a stale value.
	always @(negedge clk)
		tgl <= ~tgl;

	// Each line carries the level of whichever party drives it.
	always_comb
		line = (~dev_oe_n & dev_out) | (dev_oe_n & hen & hv) | (dev_oe_n & ~hen & {tgl, ~tgl, tgl, ~tgl});

	////////////////////////////////////////////////////////////////
	// Pin sequences, all changed at the core clock's falling edge.
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	task automatic start();
		tick(1);
		sclk = mode3;
		tick(4);
		sel_n = 1'b0;
		tick(4);
	endtask : start

	// Shifts n bits out, w lanes at a time, most significant first.
	task automatic send(input logic [31:0] v, input int n, input int w);
		int i;
		for (i = n - w; i >= 0; i -= w)
		begin
			sclk = 1'b0;
			hen  = 4'((1 << w) - 1);
			hv   = 4'(v >> i) & hen;
			tick(4);
			sclk = 1'b1;
			tick(4);
		end
	endtask : send

	// Dummy clocks with every line released.
	task automatic idle(input int n);
		hen = 4'h0;
		repeat (n)
		begin
			sclk = 1'b0;
			tick(4);
			sclk = 1'b1;
			tick(4);
		end
	endtask : idle

	// Takes one byte, w bits at a time, each just before a rising edge.
	task automatic rd(input int w, output logic [7:0] b);
		int k;
		b = 8'h00;
		for (k = 0; k < 8; k += w)
		begin
			sclk = 1'b0;
			tick(4);
			b    = (b << w) | 8'(w == 1 ? {3'h0, line[1]} : line & 4'((1 << w) - 1));
			sclk = 1'b1;
			tick(4);
		end
	endtask : rd

	task automatic stop();
		if (!mode3)
		begin
			sclk = 1'b0;
			tick(4);
		end
		sel_n = 1'b1;
		hen   = 4'h0;
		tick(8);
	endtask : stop

	task automatic pulse(input int n);
		rst_n = 1'b0;
		tick(n);
		rst_n = 1'b1;
		tick(6);
	endtask : pulse
endmodule : sfb_host_model
`default_nettype wire

// >>> dv/tb_serial_flash_bus_mode_reset.sv
// Self-checking bench for the serial flash bus front end.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_bus_mode_reset;
	logic        clk;
	logic        srst;
	logic [3:0]  line;
	logic        sclk;
	logic        sel_n;
	logic        rst_n;
	logic [3:0]  dout;
	logic [3:0]  oe_n;
	logic        qmode;
	logic [7:0]  code;
	logic        cv;
	logic [25:0] addr;
	logic [9:0]  blk;
	logic [13:0] sec;
	logic [7:0]  rd_data;
	logic [7:0]  wr_data;
	logic        wv;
	logic [7:0]  b;
	logic [7:0]  wr_log [0:3];
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;
	int          cv_n = 0;
	int          wr_n = 0;

	sfb_front i_sfb_front (.CORE_CLK(clk), .SRST(srst), .SERIAL_CLOCK_IN(sclk), .SELECT_LOW(sel_n),
		.HW_RESET_LOW(rst_n), .DATA_LINE_IN(line), .DATA_LINE_OUT(dout), .DATA_LINE_OE_N(oe_n),
		.QUAD_COMMAND_MODE(qmode), .CMD_CODE(code), .CMD_VALID(cv), .MEM_ADDR(addr), .BLOCK_NUM(blk),
		.SECTOR_NUM(sec), .RD_DATA(rd_data), .WR_DATA(wr_data), .WR_VALID(wv));

	sfb_host_model i_sfb_host_model (.clk(clk), .dev_out(dout), .dev_oe_n(oe_n), .line(line),
		.sclk(sclk), .sel_n(sel_n), .rst_n(rst_n));

	// The array answers each byte address with a fixed pattern.
	assign rd_data = addr[7:0] ^ 8'h5a;

	// Clock of 50 ns period.
	initial
		clk = 1'b0;
	always #25 clk = ~clk;

	// Counts command and write pulses and cuts a hang short.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cv === 1'b1)
			cv_n <= cv_n + 1;
		if (wv === 1'b1)
		begin
			wr_log[2'(wr_n)] <= wr_data;
			wr_n             <= wr_n + 1;
		end
		if (cyc == 12000)
		begin
			err_total = err_total + 1;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic frame(input logic [7:0] v, input int w);
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'(v), 8, w);
		i_sfb_host_model.stop();
	endtask : frame

	task automatic t_mode();
		int n;
		n = cv_n;
		i_sfb_host_model.mode3 = 1'b1;
		frame(8'h38, 1);
		chk(32'(cv_n - n), 32'h1, "pulses");
		chk(32'(code), 32'h38, "code");
		chk(32'(qmode), 32'h1, "enter");
		frame(8'h38, 4);
		chk(32'(qmode), 32'h1, "enter again");
		frame(8'hff, 4);
		chk(32'(code), 32'hff, "quad code");
		chk(32'(qmode), 32'h0, "exit");
		frame(8'hff, 1);
		chk(32'(qmode), 32'h0, "exit when ordinary");
		i_sfb_host_model.mode3 = 1'b0;
		n = cv_n;
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'h07, 5, 1);
		i_sfb_host_model.stop();
		chk(32'(cv_n - n), 32'h0, "partial code");
		chk(32'(qmode), 32'h0, "partial mode");
	endtask : t_mode

	task automatic t_dual();
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'h3c, 8, 1);
		i_sfb_host_model.send(32'h03fff0fe, 32, 1);
		i_sfb_host_model.idle(8);
		chk(32'(addr), 32'h03fff0fe, "address");
		chk(32'(blk), 32'h3ff, "block");
		chk(32'(sec), 32'h3fff, "sector");
		i_sfb_host_model.rd(2, b);
		chk(32'(oe_n), 32'hc, "dual drive");
		chk(32'(b), 32'(8'hfe ^ 8'h5a), "dual byte 0");
		i_sfb_host_model.rd(2, b);
		chk(32'(b), 32'(8'hff ^ 8'h5a), "dual byte 1");
		i_sfb_host_model.stop();
		chk(32'(oe_n), 32'hf, "release");
	endtask : t_dual

	task automatic t_quad();
		int n;
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'h6b, 8, 1);
		i_sfb_host_model.send(32'h012345, 24, 1);
		i_sfb_host_model.idle(8);
		i_sfb_host_model.rd(4, b);
		chk(32'(oe_n), 32'h0, "quad drive");
		chk(32'(b), 32'(8'h45 ^ 8'h5a), "quad byte");
		i_sfb_host_model.stop();
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'hec, 8, 1);
		i_sfb_host_model.send(32'h0155aa32, 32, 4);
		i_sfb_host_model.idle(8);
		chk(32'(blk), 32'h155, "quad io block");
		chk(32'(sec), 32'h155a, "quad io sector");
		i_sfb_host_model.rd(4, b);
		chk(32'(b), 32'(8'h32 ^ 8'h5a), "quad io byte");
		i_sfb_host_model.stop();
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'hbb, 8, 1);
		i_sfb_host_model.send(32'h0a0b21, 24, 2);
		i_sfb_host_model.idle(8);
		chk(32'(addr), 32'h000a0b21, "two-line address");
		i_sfb_host_model.rd(2, b);
		chk(32'(b), 32'(8'h21 ^ 8'h5a), "dual io byte");
		i_sfb_host_model.stop();
		n = wr_n;
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'h32, 8, 1);
		i_sfb_host_model.send(32'h000200, 24, 1);
		i_sfb_host_model.send(32'ha5, 8, 4);
		i_sfb_host_model.send(32'h3c, 8, 4);
		i_sfb_host_model.stop();
		chk(32'(wr_n - n), 32'h2, "writes");
		chk(32'(wr_log[2'(n)]), 32'ha5, "write 0");
		chk(32'(wr_log[2'(n + 1)]), 32'h3c, "write 1");
	endtask : t_quad

	task automatic t_reset();
		frame(8'h38, 1);
		frame(8'h66, 4);
		frame(8'h99, 4);
		chk(32'(qmode), 32'h0, "soft reset");
		frame(8'h38, 1);
		i_sfb_host_model.pulse(10);
		chk(32'(qmode), 32'h1, "short pulse");
		i_sfb_host_model.pulse(30);
		chk(32'(qmode), 32'h0, "hard reset");
		i_sfb_host_model.start();
		i_sfb_host_model.send(32'h3b, 8, 1);
		i_sfb_host_model.send(32'h000010, 24, 1);
		i_sfb_host_model.idle(8);
		chk(32'(addr), 32'h10, "short address");
		i_sfb_host_model.rd(2, b);
		chk(32'(b), 32'(8'h10 ^ 8'h5a), "dual out byte");
		i_sfb_host_model.pulse(30);
		chk(32'(oe_n), 32'hf, "reset mid read");
		chk(32'(addr), 32'h0, "address default");
		i_sfb_host_model.stop();
	endtask : t_reset

	// Main sequence after reset.
	initial
	begin
		srst = 1'b1;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		chk(32'(oe_n), 32'hf, "idle drive");
		chk(32'(qmode), 32'h0, "idle mode");
		t_mode();
		t_dual();
		t_quad();
		t_reset();
		summarize();
	end
endmodule : tb_serial_flash_bus_mode_reset
`default_nettype wire

// >>> rtl/sfb_front.sv
// Serial flash bus front end: command shifter, mode switching and data lanes.
`timescale 1ns/1ps
`default_nettype none
module sfb_front (
	input  wire logic        CORE_CLK,
	input  wire logic        SRST,
	input  wire logic        SERIAL_CLOCK_IN,
	input  wire logic        SELECT_LOW,
	input  wire logic        HW_RESET_LOW,
	input  wire logic [3:0]  DATA_LINE_IN,
	output var  logic [3:0]  DATA_LINE_OUT,
	output var  logic [3:0]  DATA_LINE_OE_N,
	output var  logic        QUAD_COMMAND_MODE,
	output var  logic [7:0]  CMD_CODE,
	output var  logic        CMD_VALID,
	output var  logic [25:0] MEM_ADDR,
	output var  logic [9:0]  BLOCK_NUM,
	output var  logic [13:0] SECTOR_NUM,
	input  wire logic [7:0]  RD_DATA,
	output var  logic [7:0]  WR_DATA,
	output var  logic        WR_VALID
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and reset qualification.

	logic [6:0]           pins_s;
	logic                 rst_low_s;
	logic                 sclk_s;
	logic                 cs_s;
	logic [3:0]           io_s;
	logic                 hw_rst;
	logic                 rst_all;
	sfb_pkg::front_s      cur;
	sfb_pkg::front_s      next_cur;

	// Select resets high so an idle bus never starts a command.
	sfb_sync2 #(.WIDTH(7), .RST_VAL(sfb_pkg::PIN_IDLE)) u_sync (
		.clk      (CORE_CLK),
		.srst     (SRST),
		.async_in ({HW_RESET_LOW, SERIAL_CLOCK_IN, SELECT_LOW, DATA_LINE_IN}),
		.sync_out (pins_s)
	);

	assign rst_low_s = ~pins_s[6];
	assign sclk_s    = pins_s[5];
	assign cs_s      = pins_s[4];
	assign io_s      = pins_s[3:0];

	sfb_reset_filter u_rst (
		.clk          (CORE_CLK),
		.srst         (SRST),
		.pin_low_sync (rst_low_s),
		.hw_rst       (hw_rst)
	);

	// The pin reset acts in every phase and mode.
	assign rst_all = SRST | hw_rst;

	////////////////////////////////////////////////////////////////////////////
	// Lane helpers.

	// Shifts w input bits in; line 0 carries the lone bit of a single-line phase.
	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] d, input logic [2:0] w);
		case (w)
			3'h1:    shift_in = {sh[6:0], d[0]};
			3'h2:    shift_in = {sh[5:0], d[1:0]};
			default: shift_in = {sh[3:0], d};
		endcase
	endfunction : shift_in

	// Places the top w bits of a byte on the lanes; single-line output uses line 1.
	function automatic logic [3:0] lane_out(input logic [7:0] v, input logic [2:0] w);
		case (w)
			3'h1:    lane_out = {2'b00, v[7], 1'b0};
			3'h2:    lane_out = {2'b00, v[7:6]};
			default: lane_out = v[7:4];
		endcase
	endfunction : lane_out

	// Lines that the device drives for a given width, active low.
	function automatic logic [3:0] lane_oe_n(input logic [2:0] w);
		case (w)
			3'h1:    lane_oe_n = 4'b1101;
			3'h2:    lane_oe_n = 4'b1100;
			default: lane_oe_n = 4'b0000;
		endcase
	endfunction : lane_oe_n

	// Returns {valid, read, four-byte, address lanes, data lanes} for data commands.
	function automatic logic [8:0] decode(input logic [7:0] c);
		case (c)
			sfb_pkg::CMD_DUAL_OUT:   decode = {3'b110, 3'h1, 3'h2};
			sfb_pkg::CMD_DUAL_OUT4:  decode = {3'b111, 3'h1, 3'h2};
			sfb_pkg::CMD_DUAL_IO:    decode = {3'b110, 3'h2, 3'h2};
			sfb_pkg::CMD_DUAL_IO4:   decode = {3'b111, 3'h2, 3'h2};
			sfb_pkg::CMD_QUAD_OUT:   decode = {3'b110, 3'h1, 3'h4};
			sfb_pkg::CMD_QUAD_OUT4:  decode = {3'b111, 3'h1, 3'h4};
			sfb_pkg::CMD_QUAD_IO:    decode = {3'b110, 3'h4, 3'h4};
			sfb_pkg::CMD_QUAD_IO4:   decode = {3'b111, 3'h4, 3'h4};
			sfb_pkg::CMD_QUAD_PROG:  decode = {3'b100, 3'h1, 3'h4};
			sfb_pkg::CMD_QUAD_PROG4: decode = {3'b101, 3'h1, 3'h4};
			default:                 decode = 9'h000;
		endcase
	endfunction : decode

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	logic       rise;
	logic       fall;
	logic       cs_rise;
	logic [2:0] w;
	logic [7:0] sh_new;
	logic [3:0] bits_new;
	logic [8:0] info;
	logic [7:0] rd_v;

	// Edges of the sampled clock; no edge assumes an idle level, so mode 0 and 3 both work.
	assign rise    = sclk_s & ~cur.sclk_d & ~cs_s;
	assign fall    = ~sclk_s & cur.sclk_d & ~cs_s;
	assign cs_rise = cs_s & ~cur.cs_d;

	always_comb
	begin
		next_cur           = cur;
		next_cur.sclk_d    = sclk_s;
		next_cur.cs_d      = cs_s;
		next_cur.cmd_valid = 1'b0;
		next_cur.wr_valid  = 1'b0;
		// Command code uses four lines only in quad command mode.
		case (cur.st)
			sfb_pkg::ST_CMD:  w = cur.quad ? 3'h4 : 3'h1;
			sfb_pkg::ST_ADDR: w = cur.alane;
			default:          w = cur.dlane;
		endcase
		sh_new   = shift_in(cur.sh, io_s, w);
		bits_new = cur.bits + {1'b0, w};
		info     = decode(sh_new);
		rd_v     = (cur.bits == 4'h0) ? RD_DATA : cur.sh;

		if (cs_s)
		begin
			// Select high ends the command; a partly shifted code is dropped.
			next_cur.st   = sfb_pkg::ST_CMD;
			next_cur.bits = 4'h0;
			next_cur.oe_n = sfb_pkg::OE_N_RELEASED;
			if (cs_rise && cur.st == sfb_pkg::ST_DONE)
			begin
				next_cur.arm = (cur.cmd == sfb_pkg::CMD_RESET_EN);
				if (cur.cmd == sfb_pkg::CMD_QUAD_ENTER && !cur.quad)
					next_cur.quad = 1'b1;
				else if (cur.cmd == sfb_pkg::CMD_QUAD_EXIT && cur.quad)
					next_cur.quad = 1'b0;
				else if (cur.cmd == sfb_pkg::CMD_RESET && cur.arm)
					next_cur.quad = 1'b0;
			end
			else if (cs_rise)
				next_cur.arm = 1'b0;
		end
		else if (rise)
		begin
			// All input bits are taken on the rising edge.
			case (cur.st)
				sfb_pkg::ST_CMD:
				begin
					next_cur.sh   = sh_new;
					next_cur.bits = bits_new;
					if (bits_new == sfb_pkg::BYTE_BITS)
					begin
						next_cur.cmd       = sh_new;
						next_cur.cmd_out   = sh_new;
						next_cur.cmd_valid = 1'b1;
						next_cur.bits      = 4'h0;
						next_cur.is_read   = info[7];
						next_cur.abytes    = info[6] ? sfb_pkg::ADDR4_BYTES : sfb_pkg::ADDR3_BYTES;
						next_cur.alane     = cur.quad ? 3'h4 : info[5:3];
						next_cur.dlane     = cur.quad ? 3'h4 : info[2:0];
						if (info[8])
							next_cur.addr = 32'h0; // A short address must not inherit old upper bits.
						next_cur.st        = info[8] ? sfb_pkg::ST_ADDR : sfb_pkg::ST_DONE;
					end
				end
				sfb_pkg::ST_ADDR:
				begin
					next_cur.sh   = sh_new;
					next_cur.bits = bits_new;
					if (bits_new == sfb_pkg::BYTE_BITS)
					begin
						next_cur.addr   = {cur.addr[23:0], sh_new};
						next_cur.bits   = 4'h0;
						next_cur.abytes = cur.abytes - 3'h1;
						next_cur.dcnt   = sfb_pkg::DUMMY_CLKS;
						if (cur.abytes == 3'h1)
							next_cur.st = cur.is_read ? sfb_pkg::ST_DUMMY : sfb_pkg::ST_PROG;
					end
				end
				sfb_pkg::ST_DUMMY:
				begin
					next_cur.dcnt = cur.dcnt - 4'h1;
					if (cur.dcnt == 4'h1)
						next_cur.st = sfb_pkg::ST_READ;
				end
				sfb_pkg::ST_PROG:
				begin
					next_cur.sh   = sh_new;
					next_cur.bits = bits_new;
					if (bits_new == sfb_pkg::BYTE_BITS)
					begin
						next_cur.bits     = 4'h0;
						next_cur.wr_data  = sh_new;
						next_cur.wr_valid = 1'b1;
						next_cur.addr     = cur.addr + 32'h1;
					end
				end
				default:
				begin
					next_cur.st = cur.st;
				end
			endcase
		end
		else if (fall && cur.st == sfb_pkg::ST_READ)
		begin
			// Drive the next bits on the falling edge so the host samples on the next rise.
			next_cur.io_out = lane_out(rd_v, w);
			next_cur.oe_n   = lane_oe_n(w);
			next_cur.sh     = rd_v << w;
			next_cur.bits   = bits_new & 4'h7;
			if (bits_new == sfb_pkg::BYTE_BITS)
				next_cur.addr = cur.addr + 32'h1;
		end

		// Block and sector numbers follow the address.
		next_cur.block  = next_cur.addr[sfb_pkg::ADDR_MSB:sfb_pkg::BLOCK_LSB];
		next_cur.sector = next_cur.addr[sfb_pkg::ADDR_MSB:sfb_pkg::SECTOR_LSB];
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	// Any reset returns to standby, ordinary serial mode and released lines.
	always_ff @(posedge CORE_CLK)
	begin
		if (rst_all)
		begin
			cur        <= '0;
			cur.st     <= sfb_pkg::ST_CMD;
			cur.cs_d   <= 1'b1;
			cur.quad   <= 1'b0;
			cur.oe_n   <= sfb_pkg::OE_N_RELEASED;
			cur.abytes <= sfb_pkg::ADDR3_BYTES;
			cur.alane  <= 3'h1;
			cur.dlane  <= 3'h1;
		end
		else
			cur <= next_cur;
	end

	assign DATA_LINE_OUT     = cur.io_out;
	assign DATA_LINE_OE_N    = cur.oe_n;
	assign QUAD_COMMAND_MODE = cur.quad;
	assign CMD_CODE          = cur.cmd_out;
	assign CMD_VALID         = cur.cmd_valid;
	assign MEM_ADDR          = cur.addr[sfb_pkg::ADDR_MSB:0];
	assign BLOCK_NUM         = cur.block;
	assign SECTOR_NUM        = cur.sector;
	assign WR_DATA           = cur.wr_data;
	assign WR_VALID          = cur.wr_valid;

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_end_of(logic [7:0] code);
		cs_rise && cur.st == sfb_pkg::ST_DONE && cur.cmd == code;
	endsequence

	property p_release;
		@(posedge CORE_CLK) disable iff (rst_all) cs_s |=> cur.oe_n == 4'hf;
	endproperty
	a_release: assert property (p_release) else $error("Lines still driven with select high.");

	property p_mode_stable;
		@(posedge CORE_CLK) disable iff (rst_all) !cs_rise |=> $stable(cur.quad);
	endproperty
	a_mode_stable: assert property (p_mode_stable) else $error("Mode changed inside a command.");

	property p_enter;
		@(posedge CORE_CLK) disable iff (rst_all) s_end_of(sfb_pkg::CMD_QUAD_ENTER) |=> cur.quad;
	endproperty
	a_enter: assert property (p_enter) else $error("Enter command did not set quad mode.");

	property p_exit;
		@(posedge CORE_CLK) disable iff (rst_all) s_end_of(sfb_pkg::CMD_QUAD_EXIT) |=> !cur.quad;
	endproperty
	a_exit: assert property (p_exit) else $error("Exit command did not clear quad mode.");

	property p_soft_reset;
		@(posedge CORE_CLK) disable iff (rst_all) s_end_of(sfb_pkg::CMD_RESET) and cur.arm |=> !cur.quad && !cur.arm;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("Armed reset left quad mode set.");

	property p_hw_reset;
		@(posedge CORE_CLK) disable iff (SRST) hw_rst |=> !cur.quad && cur.st == sfb_pkg::ST_CMD && cur.oe_n == 4'hf;
	endproperty
	a_hw_reset: assert property (p_hw_reset) else $error("Pin reset did not restore defaults.");

	property p_drive_on_fall;
		@(posedge CORE_CLK) disable iff (rst_all) !fall |=> $stable(cur.io_out);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall) else $error("Output bits moved off a falling edge.");

	property p_sample_on_rise;
		@(posedge CORE_CLK) disable iff (rst_all) cur.st == sfb_pkg::ST_ADDR && !rise && !cs_s |=> $stable(cur.sh);
	endproperty
	a_sample_on_rise: assert property (p_sample_on_rise) else $error("Address bits taken off a rising edge.");

	property p_dual_lanes;
		@(posedge CORE_CLK) disable iff (rst_all)
			cur.st == sfb_pkg::ST_READ && cur.oe_n == 4'b1100 |-> cur.cmd[7:4] inside {4'h3, 4'hb};
	endproperty
	a_dual_lanes: assert property (p_dual_lanes) else $error("Two-line drive outside a dual read.");

	property p_blocks;
		@(posedge CORE_CLK) disable iff (rst_all)
			BLOCK_NUM == MEM_ADDR[25:16] && SECTOR_NUM == {BLOCK_NUM, MEM_ADDR[15:12]};
	endproperty
	a_blocks: assert property (p_blocks) else $error("Block is not sixteen sectors.");

endmodule : sfb_front
`default_nettype wire

// >>> rtl/sfb_pkg.sv
// Constants, types and state layout of the serial flash bus front end.
// What this block does
// - Works with host clock mode 0 or mode 3, either idle level.
// - Every input bit on every active line is taken at clock rising edge.
// - Output bits change at clock falling edge for host rising-edge sampling.
// - Two-line transfer only for the dual output and dual address/data reads.
// - In dual commands lines 0 and 1 turn two-way; each side drives its phase.
// - Four-line transfer for quad output, quad address/data reads and quad program.
// - In quad commands the write-protect pin turns two-way data line 2.
// - Quad command mode entered only by enter command, left by exit command, enable-reset then reset, or any reset.
// - In quad command mode the command code itself arrives on four lines.
// - Ordinary serial mode and quad command mode are exclusive, one always active.
// - Power-up and enable-reset then reset leave the device in ordinary serial mode.
// - Reset pin held low for the minimum pulse time resets the device.
// - After hardware reset the device is in standby with power-on defaults.
// - Reset pin always resets, whatever the configuration or operation state.
// - Array is 64 KB blocks of sixteen 4 KB sectors of sixteen 256-byte pages.
// - Blocks 0 to 1023, sectors 0 to 16383 upward; last sector ends at top byte.
package sfb_pkg;

	// Command codes recognised by the front end.
	localparam logic [7:0] CMD_DUAL_OUT    = 8'h3b;
	localparam logic [7:0] CMD_DUAL_OUT4   = 8'h3c;
	localparam logic [7:0] CMD_DUAL_IO     = 8'hbb;
	localparam logic [7:0] CMD_DUAL_IO4    = 8'hbc;
	localparam logic [7:0] CMD_QUAD_OUT    = 8'h6b;
	localparam logic [7:0] CMD_QUAD_OUT4   = 8'h6c;
	localparam logic [7:0] CMD_QUAD_IO     = 8'heb;
	localparam logic [7:0] CMD_QUAD_IO4    = 8'hec;
	localparam logic [7:0] CMD_QUAD_PROG   = 8'h32;
	localparam logic [7:0] CMD_QUAD_PROG4  = 8'h34;
	localparam logic [7:0] CMD_QUAD_ENTER  = 8'h38;
	localparam logic [7:0] CMD_QUAD_EXIT   = 8'hff;
	localparam logic [7:0] CMD_RESET_EN    = 8'h66;
	localparam logic [7:0] CMD_RESET       = 8'h99;

	// Field positions of the byte address.
	localparam int ADDR_MSB   = 25;
	localparam int BLOCK_LSB  = 16;
	localparam int SECTOR_LSB = 12;
	localparam int PAGE_LSB   = 8;

	// Shift and phase counts.
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [3:0] DUMMY_CLKS  = 4'h8;
	localparam logic [2:0] ADDR3_BYTES = 3'h3;
	localparam logic [2:0] ADDR4_BYTES = 3'h4;

	// Minimum reset pulse time and its length in core clock cycles, rounded up.
	localparam int CLK_PERIOD_NS        = 50;
	localparam int RESET_PULSE_MIN_NS   = 1000;
	localparam int RESET_PULSE_CYCLES   = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Values after reset.
	localparam logic [3:0] OE_N_RELEASED = 4'hf;
	localparam logic [6:0] PIN_IDLE      = 7'h50; // Reset pin high, clock low, select high, data low.

	typedef enum logic [2:0] {
		ST_CMD   = 3'b000,
		ST_ADDR  = 3'b001,
		ST_DUMMY = 3'b010,
		ST_READ  = 3'b011,
		ST_PROG  = 3'b100,
		ST_DONE  = 3'b101
	} phase_e;

	typedef struct packed {
		phase_e      st;
		logic        sclk_d;
		logic        cs_d;
		logic [7:0]  sh;
		logic [7:0]  cmd;
		logic [3:0]  bits;
		logic [2:0]  abytes;
		logic [3:0]  dcnt;
		logic [31:0] addr;
		logic        is_read;
		logic [2:0]  alane;
		logic [2:0]  dlane;
		logic        quad;
		logic        arm;
		logic [3:0]  io_out;
		logic [3:0]  oe_n;
		logic        cmd_valid;
		logic [7:0]  cmd_out;
		logic [7:0]  wr_data;
		logic        wr_valid;
		logic [9:0]  block;
		logic [13:0] sector;
	} front_s;

endpackage : sfb_pkg

// >>> rtl/sfb_reset_filter.sv
// Qualifies the reset pin: reset only after it stays low for the minimum pulse time.
`timescale 1ns/1ps
`default_nettype none
module sfb_reset_filter (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic pin_low_sync,
	output var  logic hw_rst
);

	logic [15:0] cnt;

	// Counts low cycles; a short glitch never reaches the count.
	always_ff @(posedge clk)
	begin
		if (srst || !pin_low_sync)
		begin
			cnt    <= 16'h0000;
			hw_rst <= 1'b0;
		end
		else if (cnt >= 16'(sfb_pkg::RESET_PULSE_CYCLES - 1))
			hw_rst <= 1'b1;
		else
			cnt <= cnt + 16'h0001;
	end

endmodule : sfb_reset_filter
`default_nettype wire

// >>> rtl/sfb_sync2.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module sfb_sync2 #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta     <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule : sfb_sync2
`default_nettype wire
